// *** dv/monitor_model.sv ***
`timescale 1ns/1ps
// =============================================================
// Safety monitor: reads one word per frame, mode 0
module monitor_model (
    input wire logic core_clk, // Bench clock
    input wire logic link_miso, // Data from block
    output logic link_sclk, // Serial clock, still outside frames
    output logic link_cs_n, // Select, low active
    output logic [15:0] rx_word, // Last word read
    output logic rx_done // One-cycle strobe per word
);
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        rx_word = 16'h0000;
        rx_done = 1'b0;
    end
    // Always exactly 16 clocks, half period 4 core cycles
    task automatic read_word();
        @(negedge core_clk) link_cs_n = 1'b0;
        repeat (4) @(negedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            repeat (4) @(negedge core_clk);
            link_sclk = 1'b1;
            rx_word[i] = link_miso;
            repeat (4) @(negedge core_clk);
            link_sclk = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        link_cs_n = 1'b1;
        rx_done = 1'b1;
        @(negedge core_clk) rx_done = 1'b0;
        repeat (6) @(negedge core_clk); // Let enable drop first
    endtask : read_word
endmodule : monitor_model

// *** dv/readout_monitor.sv ***
`timescale 1ns/1ps
// =============================================================
// Port checker for the readout port
module readout_monitor (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic frame_valid, // Frame strobe
    input wire logic link_cs_n, // Select
    input wire logic link_miso, // Data
    input wire logic link_miso_oe, // Enable
    input wire logic queue_full // Full
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_quiet_undriven: assert property (!link_miso_oe |-> !link_miso)
        else $error("data high while undriven");
    a_idle_no_drive: assert property (link_cs_n[*5] |-> !link_miso_oe)
        else $error("driving while deselected");
    a_select_drives: assert property ($fell(link_cs_n) ##0
        !link_cs_n[*5] |-> link_miso_oe) else $error("no drive");
    a_oe_holds: assert property (link_miso_oe && !link_cs_n |=>
        link_miso_oe) else $error("enable dropped in frame");
    a_oe_rise_cause: assert property ($rose(link_miso_oe) |->
        !link_cs_n && !$past(link_cs_n, 2)) else $error("early enable");
    a_oe_fall_cause: assert property ($fell(link_miso_oe) |->
        link_cs_n && $past(link_cs_n, 2)) else $error("early release");
    a_full_cause: assert property ($rose(queue_full) |->
        $past(frame_valid) || $past(frame_valid, 2)
        || $past(frame_valid, 3)) else $error("full without frame");
    a_full_stays: assert property (link_cs_n[*4] ##0 queue_full |=>
        queue_full) else $error("entry lost without read");
endmodule : readout_monitor

bind secondary_readout_port readout_monitor u_readout_monitor (
    .core_clk(core_clk), .arst_n(arst_n), .frame_valid(frame_valid),
    .link_cs_n(link_cs_n), .link_miso(link_miso),
    .link_miso_oe(link_miso_oe), .queue_full(queue_full));

// *** dv/tb_secondary_readout_port.sv ***
`timescale 1ns/1ps
// =============================================================
// Bench
module tb_secondary_readout_port;
    logic core_clk, arst_n, frame_valid, link_sclk, link_cs_n;
    logic link_miso, link_miso_oe, queue_full, rx_done;
    logic [15:0] rx_word;
    logic miso_pin;

    // Released data line floats high through the pull-up
    assign miso_pin = link_miso_oe ? link_miso : 1'b1;
    snoop_pkg::bus_frame_t frame_in;
    logic [15:0] exp_q[$];
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'hd0d4acf2;

    secondary_readout_port u_secondary_readout_port (.core_clk(core_clk),
        .arst_n(arst_n), .frame_valid(frame_valid), .frame_in(frame_in),
        .link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_miso(link_miso), .link_miso_oe(link_miso_oe),
        .queue_full(queue_full));
    monitor_model u_monitor_model (.core_clk(core_clk),
        .link_miso(miso_pin), .link_sclk(link_sclk),
        .link_cs_n(link_cs_n), .rx_word(rx_word), .rx_done(rx_done));

    // Clock, 20 ns period
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
            err_count++;
        end
    endtask : check

    task automatic send(input snoop_pkg::bus_frame_t f);
        @(negedge core_clk);
        frame_valid = 1'b1;
        frame_in = f;
        @(negedge core_clk) frame_valid = 1'b0;
    endtask : send

    // Request, optional disarming command, response; note if kept
    task automatic cap(input logic [1:0] ch, input logic e,
                       input logic dis, input logic keep);
        logic [3:0] a;
        logic [9:0] d;
        a = 4'($random(seed));
        d = 10'($random(seed));
        send({ch, 1'b1, a, 4'h0, 10'h000, 1'b0});
        if (dis)
            send({ch, 1'b1, a, 4'h5, 10'h000, 1'b0});
        send({ch, 1'b0, a, 4'h0, d, e});
        if (keep)
            exp_q.push_back({a, e ? 10'h000 : d, ch[0], e});
    endtask : cap

    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // Watcher: oldest note against each word read
    always @(posedge core_clk) begin
        if (rx_done === 1'b1) begin
            if (exp_q.size() == 0)
                check(16'hdead, rx_word);
            else
                check(exp_q.pop_front(), rx_word);
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        frame_valid = 1'b0;
        frame_in = '0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        exp_q.push_back(16'h0000);
        u_monitor_model.read_word();
        cap(2'd0, 1'b0, 1'b0, 1'b0);
        cap(2'd1, 1'b0, 1'b0, 1'b0);
        cap(2'd2, 1'b0, 1'b1, 1'b0);
        cap(2'd2, 1'b0, 1'b0, 1'b1);
        cap(2'd3, 1'b1, 1'b0, 1'b1);
        cap(2'd3, 1'b0, 1'b0, 1'b1);
        cap(2'd2, 1'b1, 1'b0, 1'b1);
        repeat (3) @(negedge core_clk);
        check(16'h0001, {15'h0000, queue_full});
        cap(2'd3, 1'b0, 1'b0, 1'b0);
        exp_q.push_back(16'h0000);
        repeat (5) u_monitor_model.read_word();
        check(16'h0000, {15'h0000, queue_full});
        check(16'h0000, 16'(exp_q.size()));
        finish_test();
    end
endmodule : tb_secondary_readout_port

// *** rtl/secondary_readout_port.sv ***
`timescale 1ns/1ps
`include "snoop_params.svh"
module secondary_readout_port (
    input wire logic core_clk,                  // 50 MHz system clock
    input wire logic arst_n,                    // Async reset, active low
    input wire logic frame_valid,               // Decoded frame strobe
    input wire snoop_pkg::bus_frame_t frame_in, // Any channel's frame
    input wire logic link_sclk,                 // Monitor serial clock pin
    input wire logic link_cs_n,                 // Monitor select pin, low active
    output logic link_miso,                     // Serial data out
    output logic link_miso_oe,                  // High while driving data
    output logic queue_full                     // Queue holds four entries
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] sclk_sync, cs_sync;
    logic sclk_q;
    logic [1:0] next_sclk_sync, next_cs_sync;
    logic next_sclk_q;

    // Two flops per pin before use
    always_comb begin
        next_sclk_sync = {sclk_sync[0], link_sclk};
        next_cs_sync = {cs_sync[0], link_cs_n};
        next_sclk_q = sclk_sync[1];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            sclk_q <= 1'b0;
        end else begin
            sclk_sync <= next_sclk_sync;
            cs_sync <= next_cs_sync;
            sclk_q <= next_sclk_q;
        end
    end

    logic cs_act, sclk_rise, sclk_fall;
    assign cs_act = ~cs_sync[1];
    assign sclk_rise = sclk_sync[1] & ~sclk_q;
    assign sclk_fall = ~sclk_sync[1] & sclk_q;

    // ==========================================================
    // Snoop: watch channels, arm on request, capture response
    // ==========================================================
    logic [3:0] armed;      // per channel: request seen
    logic [3:0] arm_addr [4];
    logic [3:0] next_armed;
    logic [3:0] next_arm_addr [4];
    logic push;
    snoop_pkg::entry_t push_entry;
    logic watched;

    assign watched = (frame_in.chan == `MON_CH_A) ||
                     (frame_in.chan == `MON_CH_B);

    always_comb begin
        next_armed = armed;
        next_arm_addr = arm_addr;
        push = 1'b0;
        push_entry = '0;
        if (frame_valid && watched) begin
            if (frame_in.is_cmd) begin
                // A zero request re-arms with its address; any other command ends a pending capture
                next_armed[frame_in.chan] =
                    (frame_in.cmd == `CMD_AN_ZERO);
                next_arm_addr[frame_in.chan] = frame_in.addr;
            end else if (armed[frame_in.chan]) begin
                next_armed[frame_in.chan] = 1'b0;
                push = 1'b1;
                push_entry.addr = arm_addr[frame_in.chan];
                push_entry.chan_b = (frame_in.chan == `MON_CH_B);
                push_entry.err = frame_in.err;
                push_entry.data = frame_in.err ? 10'h000
                                               : frame_in.data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                arm_addr[i] <= 4'h0;
            end
        end else begin
            armed <= next_armed;
            arm_addr <= next_arm_addr;
        end
    end

    // ==========================================================
    // Queue of captured entries
    // ==========================================================
    snoop_pkg::entry_t q_mem [`QUEUE_DEPTH];
    logic [`QUEUE_PTR_BITS-1:0] wr_ptr, rd_ptr;
    logic [`QUEUE_CNT_BITS-1:0] count;
    snoop_pkg::entry_t next_q_mem [`QUEUE_DEPTH];
    logic [`QUEUE_PTR_BITS-1:0] next_wr_ptr, next_rd_ptr;
    logic [`QUEUE_CNT_BITS-1:0] next_count;
    logic next_queue_full;
    logic pop;
    logic do_push;

    // New captures are dropped when full: the oldest are kept
    assign do_push = push && (count != `QUEUE_CNT_BITS'(`QUEUE_DEPTH));

    always_comb begin
        next_q_mem = q_mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (do_push) begin
            next_q_mem[wr_ptr] = push_entry;
            next_wr_ptr = wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
        next_count = count + (do_push ? 3'h1 : 3'h0)
                           - (pop ? 3'h1 : 3'h0);
        next_queue_full = (next_count == `QUEUE_CNT_BITS'(`QUEUE_DEPTH));
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `QUEUE_DEPTH; i++) begin
                q_mem[i] <= '0;
            end
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            count <= 3'h0;
            queue_full <= 1'b0;
        end else begin
            q_mem <= next_q_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            queue_full <= next_queue_full;
        end
    end

    // ==========================================================
    // Serial output: 16 bits, MSB first, changed on falling edge
    // ==========================================================
    snoop_pkg::link_state_t state, next_state;
    logic [`WORD_BITS-1:0] shreg, next_shreg;
    logic [4:0] bits, next_bits;
    logic next_miso, next_miso_oe;
    logic [`WORD_BITS-1:0] load_word;

    // Empty queue gives zero; nothing is popped
    assign load_word = (count != 3'h0) ? `WORD_BITS'(q_mem[rd_ptr])
                                       : `WORD_ZERO;

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bits = bits;
        next_miso = link_miso;
        next_miso_oe = link_miso_oe;
        pop = 1'b0;
        case (state)
            snoop_pkg::ST_IDLE: begin
                next_miso_oe = 1'b0;
                next_miso = 1'b0;
                if (cs_act) begin
                    // Pop at select so the word is fixed for the frame
                    pop = (count != 3'h0);
                    next_shreg = load_word;
                    next_miso = load_word[`WORD_BITS-1];
                    next_miso_oe = 1'b1;
                    next_bits = 5'h0;
                    next_state = snoop_pkg::ST_SHIFT;
                end
            end
            snoop_pkg::ST_SHIFT: begin
                // Cut frame: release and park data low at once
                if (!cs_act) begin
                    next_state = snoop_pkg::ST_IDLE;
                    next_miso = 1'b0;
                    next_miso_oe = 1'b0;
                end else if (sclk_rise) begin
                    next_bits = bits + 5'h1;
                    if (bits == 5'(`WORD_BITS - 1)) begin
                        next_state = snoop_pkg::ST_DONE;
                    end
                end else if (sclk_fall && bits != 5'h0) begin
                    next_shreg = {shreg[`WORD_BITS-2:0], 1'b0};
                    next_miso = shreg[`WORD_BITS-2];
                end
            end
            snoop_pkg::ST_DONE: begin
                // Extra clocks read zero until deselect
                next_miso = 1'b0;
                if (!cs_act) begin
                    next_state = snoop_pkg::ST_IDLE;
                    next_miso_oe = 1'b0;
                end
            end
            default: begin
                next_state = snoop_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= snoop_pkg::ST_IDLE;
            shreg <= `WORD_ZERO;
            bits <= 5'h0;
            link_miso <= 1'b0;
            link_miso_oe <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bits <= next_bits;
            link_miso <= next_miso;
            link_miso_oe <= next_miso_oe;
        end
    end
endmodule : secondary_readout_port

// *** rtl/snoop_params.svh ***
`ifndef SNOOP_PARAMS_SVH
`define SNOOP_PARAMS_SVH
// Sensor-bus channels watched by the readout port
`define MON_CH_A 2'd2
`define MON_CH_B 2'd3
// Analog channel zero request command code on the sensor bus
`define CMD_AN_ZERO 4'h0
// Readout word: [15:12] address, [11:2] data, [1] channel, [0] error
`define WORD_ADDR_MSB 15
`define WORD_DATA_MSB 11
`define WORD_CH_BIT 1
`define WORD_ERR_BIT 0
`define WORD_BITS 16
`define WORD_ZERO 16'h0000
`define QUEUE_DEPTH 4
`define QUEUE_PTR_BITS 2
`define QUEUE_CNT_BITS 3
`endif

// *** rtl/snoop_pkg.sv ***
package snoop_pkg;
    // One decoded frame seen on a sensor-bus channel
    typedef struct packed {
        logic [1:0] chan;   // channel number 0..3
        logic is_cmd;       // 1 command frame, 0 response frame
        logic [3:0] addr;   // slave address
        logic [3:0] cmd;    // command code
        logic [9:0] data;   // response data
        logic err;          // bus error on this frame
    } bus_frame_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [9:0] data;
        logic chan_b;
        logic err;
    } entry_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } link_state_t;
endpackage : snoop_pkg
